// ### madhp_pkg.sv
// shared constants and types of the muxed address/data host port
package madhp_pkg;
    localparam int DQ_W = 16;
    localparam int IDX_W = 4;
    localparam int MEM_DEPTH = 16;
    localparam int BUF_DEPTH = 2;
    localparam int CFG_W = 3;
    localparam int CFG_SYNC_MODE = 0;
    localparam int CFG_BURST = 1;
    localparam int CFG_SHORT_LAT = 2;
    // latencies held as "cycles minus one" for the wait counters
    localparam logic [1:0] LAT_LONG_M1 = 2'h1;
    localparam logic [1:0] LAT_SHORT_M1 = 2'h0;
    localparam logic [1:0] TAIL_M1 = 2'h2;
    localparam logic [1:0] BURST_M1 = 2'h3;
    localparam logic [1:0] SINGLE_M1 = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic address_valid_n;
    } madhp_ctl_t;

    localparam int PIN_W = $bits(madhp_ctl_t) + DQ_W;

    typedef struct packed {
        logic [DQ_W-1:0] addr;
        logic [DQ_W-1:0] data;
    } madhp_word_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_BEAT,
        ST_RD_HOLD,
        ST_WR_WAIT,
        ST_WR_BEAT,
        ST_WR_TAIL,
        ST_AS_RD,
        ST_AS_WR
    } madhp_state_t;
endpackage

// ### madhp_sync.sv
// two flip-flop synchroniser, also used for reset release
`timescale 1ns/1ps
`default_nettype none
module madhp_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    always_comb begin
        meta_d = d_i;
        q_d = meta_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= meta_d;
            q_o <= q_d;
        end
    end
endmodule
`default_nettype wire

// ### madhp_buf.sv
// small fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module madhp_buf #(
    parameter int W = 32,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != CW'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rp_q];

    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        if (push) begin
            mem_d[wp_q] = in_data_i;
            wp_d = (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
        end
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ### madhp_top.sv
// muxed address/data host port: pin side on the link clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - several async reads under one chip select
// - async read ends on first OE/CE release
// - several async writes under one chip select
// - async write completes on first WE/CE release
// - clocked mode samples on the shared edge
// - single read: ready at 2, drops after data
// - read data at 2, held until OE release
// - single write: ready at 2, drops 3 later
// - latency 2; optional 1 below 50 MHz
// - burst read: final word held until OE release
// - bursts are whole; ready never drops inside
// - burst write: ready at 2, drops 3 later
module madhp_top
    import madhp_pkg::*;
(
    // system side
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // straps
    input wire logic MUXED_ADDR_DATA_MODE_I,
    input wire logic BURST_MODE_I,
    input wire logic SHORT_LAT_I,
    // processor pins
    input wire logic LINK_CLK_I,
    input wire madhp_pkg::madhp_ctl_t PIN_CTL_I,
    input wire logic [madhp_pkg::DQ_W-1:0] DQ_I,
    output logic [madhp_pkg::DQ_W-1:0] DQ_O,
    output logic DQ_OE_O,
    output logic RDY_O,
    // written words
    output logic WR_VALID_O,
    input wire logic WR_READY_I,
    output madhp_pkg::madhp_word_t WR_WORD_O
);
    import madhp_pkg::*;

    function automatic logic [IDX_W-1:0] word_idx(
        input logic [DQ_W-1:0] a,
        input logic [1:0] off
    );
        word_idx = a[IDX_W-1:0] + IDX_W'(off);
    endfunction

    logic link_rst_n;
    logic [CFG_W-1:0] cfg_s;
    logic [PIN_W-1:0] pin_s;
    logic ack_s, req_s;
    logic ack_q, ack_d;
    madhp_ctl_t ctl;
    logic [DQ_W-1:0] dq_in;
    logic sync_mode, busy, rd_held, wr_held;
    logic [1:0] lat_m1, blen_m1;

    madhp_state_t state_q, state_d;
    logic [1:0] cnt_q, cnt_d, beat_q, beat_d, wlast_q, wlast_d;
    logic [DQ_W-1:0] addr_q, addr_d, dq_q, dq_d, wdat_q, wdat_d;
    logic [DQ_W-1:0] wbase_q, wbase_d;
    logic dq_oe_q, dq_oe_d, rdy_q, rdy_d, req_q, req_d;
    logic [DQ_W-1:0] mem_q [MEM_DEPTH];
    logic [DQ_W-1:0] mem_d [MEM_DEPTH];

    madhp_sync #(.W(1)) u_rst (
        .clk_i(LINK_CLK_I), .rst_n_i(ARST_N_I), .d_i(1'b1), .q_o(link_rst_n)
    );
    madhp_sync #(.W(CFG_W)) u_cfg (
        .clk_i(LINK_CLK_I), .rst_n_i(ARST_N_I),
        .d_i({SHORT_LAT_I, BURST_MODE_I, MUXED_ADDR_DATA_MODE_I}),
        .q_o(cfg_s)
    );
    madhp_sync #(.W(PIN_W)) u_pin (
        .clk_i(LINK_CLK_I), .rst_n_i(ARST_N_I),
        .d_i({PIN_CTL_I, DQ_I}), .q_o(pin_s)
    );
    madhp_sync #(.W(1)) u_ack (
        .clk_i(LINK_CLK_I), .rst_n_i(ARST_N_I), .d_i(ack_q), .q_o(ack_s)
    );

    // clocked mode shares our clock, so its pins are read raw
    assign sync_mode = cfg_s[CFG_SYNC_MODE];
    assign ctl = sync_mode ? PIN_CTL_I : madhp_ctl_t'(pin_s[PIN_W-1:DQ_W]);
    assign dq_in = sync_mode ? DQ_I : pin_s[DQ_W-1:0];
    // boot code expects the long latency; short one is opt
    assign lat_m1 = cfg_s[CFG_SHORT_LAT] ? LAT_SHORT_M1 : LAT_LONG_M1;
    assign blen_m1 = cfg_s[CFG_BURST] ? BURST_M1 : SINGLE_M1;
    assign busy = (req_q != ack_s);
    assign rd_held = !ctl.ce_n && !ctl.oe_n;
    assign wr_held = !ctl.ce_n && !ctl.we_n;
    assign DQ_O = dq_q;
    assign DQ_OE_O = dq_oe_q;
    assign RDY_O = rdy_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        beat_d = beat_q;
        addr_d = addr_q;
        dq_d = dq_q;
        dq_oe_d = dq_oe_q;
        rdy_d = rdy_q;
        wdat_d = wdat_q;
        wbase_d = wbase_q;
        wlast_d = wlast_q;
        req_d = req_q;
        mem_d = mem_q;
        // last value seen under the strobe is kept on its release
        if (!ctl.address_valid_n && !ctl.ce_n) begin
            addr_d = dq_in;
        end
        case (state_q)
            ST_IDLE: begin
                cnt_d = '0;
                beat_d = '0;
                if (sync_mode && rd_held) begin
                    state_d = ST_RD_WAIT;
                end else if (sync_mode && wr_held) begin
                    state_d = ST_WR_WAIT;
                end else if (!sync_mode && rd_held
                             && ctl.address_valid_n) begin
                    state_d = ST_AS_RD;
                    dq_d = mem_q[word_idx(addr_q, 2'h0)];
                    dq_oe_d = 1'b1;
                end else if (!sync_mode && wr_held
                             && ctl.address_valid_n && !busy) begin
                    state_d = ST_AS_WR;
                    wdat_d = dq_in;
                end
            end
            ST_RD_WAIT: begin
                if (!rd_held) begin
                    state_d = ST_IDLE;
                end else if (cnt_q == lat_m1) begin
                    state_d = ST_RD_BEAT;
                    rdy_d = 1'b1;
                    dq_oe_d = 1'b1;
                    dq_d = mem_q[word_idx(addr_q, 2'h0)];
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_RD_BEAT: begin
                if (!rd_held) begin
                    // early release drops the rest of the burst
                    state_d = ST_IDLE;
                    rdy_d = 1'b0;
                    dq_oe_d = 1'b0;
                end else if (beat_q == blen_m1) begin
                    state_d = ST_RD_HOLD;
                    rdy_d = 1'b0;
                end else begin
                    beat_d = beat_q + CNT_ONE;
                    dq_d = mem_q[word_idx(addr_q, beat_q + CNT_ONE)];
                end
            end
            ST_RD_HOLD: begin
                if (!rd_held) begin
                    state_d = ST_IDLE;
                    dq_oe_d = 1'b0;
                end
            end
            ST_WR_WAIT: begin
                // a previous hand-off still pending stretches the wait
                if (!wr_held) begin
                    state_d = ST_IDLE;
                end else if (cnt_q == lat_m1 && !busy) begin
                    state_d = ST_WR_BEAT;
                    rdy_d = 1'b1;
                end else if (cnt_q != lat_m1) begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_WR_BEAT: begin
                if (!wr_held) begin
                    // early release leaves the burst unpublished
                    state_d = ST_IDLE;
                    rdy_d = 1'b0;
                end else begin
                    mem_d[word_idx(addr_q, beat_q)] = dq_in;
                    if (beat_q == blen_m1) begin
                        state_d = ST_WR_TAIL;
                        cnt_d = '0;
                        wbase_d = addr_q;
                        wlast_d = blen_m1;
                        req_d = !req_q;
                    end else begin
                        beat_d = beat_q + CNT_ONE;
                    end
                end
            end
            ST_WR_TAIL: begin
                if (cnt_q == TAIL_M1) begin
                    state_d = ST_IDLE;
                    rdy_d = 1'b0;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            ST_AS_RD: begin
                dq_d = mem_q[word_idx(addr_q, 2'h0)];
                if (!rd_held) begin
                    state_d = ST_IDLE;
                    dq_oe_d = 1'b0;
                end
            end
            ST_AS_WR: begin
                if (!wr_held) begin
                    state_d = ST_IDLE;
                    mem_d[word_idx(addr_q, 2'h0)] = wdat_q;
                    wbase_d = addr_q;
                    wlast_d = SINGLE_M1;
                    req_d = !req_q;
                end else begin
                    wdat_d = dq_in;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge LINK_CLK_I or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            beat_q <= '0;
            addr_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            rdy_q <= 1'b0;
            wdat_q <= '0;
            wbase_q <= '0;
            wlast_q <= '0;
            req_q <= 1'b0;
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            beat_q <= beat_d;
            addr_q <= addr_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            rdy_q <= rdy_d;
            wdat_q <= wdat_d;
            wbase_q <= wbase_d;
            wlast_q <= wlast_d;
            req_q <= req_d;
            mem_q <= mem_d;
        end
    end

    // system side: storage and base are frozen while req differs from ack
    logic req_seen_q, req_seen_d, act_q, act_d;
    logic [1:0] off_q, off_d, last_q, last_d;
    logic [DQ_W-1:0] base_q, base_d;
    logic buf_ready;
    madhp_word_t buf_word;

    madhp_sync #(.W(1)) u_req (
        .clk_i(SYS_CLK_I), .rst_n_i(ARST_N_I), .d_i(req_q), .q_o(req_s)
    );

    always_comb begin
        req_seen_d = req_seen_q;
        act_d = act_q;
        ack_d = ack_q;
        off_d = off_q;
        last_d = last_q;
        base_d = base_q;
        buf_word.addr = base_q + DQ_W'(off_q);
        buf_word.data = mem_q[word_idx(base_q, off_q)];
        if (!act_q && req_s != req_seen_q) begin
            req_seen_d = req_s;
            act_d = 1'b1;
            off_d = '0;
            last_d = wlast_q;
            base_d = wbase_q;
        end else if (act_q && buf_ready) begin
            if (off_q == last_q) begin
                act_d = 1'b0;
                ack_d = !ack_q;
            end else begin
                off_d = off_q + CNT_ONE;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            req_seen_q <= 1'b0;
            act_q <= 1'b0;
            ack_q <= 1'b0;
            off_q <= '0;
            last_q <= '0;
            base_q <= '0;
        end else begin
            req_seen_q <= req_seen_d;
            act_q <= act_d;
            ack_q <= ack_d;
            off_q <= off_d;
            last_q <= last_d;
            base_q <= base_d;
        end
    end

    madhp_buf #(.W($bits(madhp_word_t)), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i(SYS_CLK_I),
        .rst_n_i(ARST_N_I),
        .in_valid_i(act_q),
        .in_ready_o(buf_ready),
        .in_data_i(buf_word),
        .out_valid_o(WR_VALID_O),
        .out_ready_i(WR_READY_I),
        .out_data_o(WR_WORD_O)
    );

    // checks, all on the link clock
    logic rd_go, wr_go;
    assign rd_go = state_q == ST_IDLE && sync_mode && rd_held;
    assign wr_go = state_q == ST_IDLE && sync_mode && wr_held && !busy;

    property p_rd_rdy;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (rd_go && !cfg_s[CFG_SHORT_LAT]) ##1 rd_held[*2]
            |-> ##1 (rdy_q && dq_oe_q);
    endproperty
    a_rd_rdy: assert property (p_rd_rdy) else $error("read ready late");
    property p_rd_early;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (rd_go && !cfg_s[CFG_SHORT_LAT]) |-> ##1 !rdy_q ##1 !rdy_q;
    endproperty
    a_rd_early: assert property (p_rd_early) else $error("ready early");
    property p_rd_single;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        ($rose(rdy_q) && state_q == ST_RD_BEAT && !cfg_s[CFG_BURST])
            |=> !rdy_q && dq_q == $past(dq_q);
    endproperty
    a_rd_single: assert property (p_rd_single) else $error("rdy held");
    property p_rd_hold;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (state_q == ST_RD_HOLD && rd_held) |=> dq_oe_q && $stable(dq_q);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("data moved");
    property p_rd_burst;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        ($rose(rdy_q) && state_q == ST_RD_BEAT && cfg_s[CFG_BURST])
            ##0 rd_held[*4] |-> rdy_q ##1 !rdy_q;
    endproperty
    a_rd_burst: assert property (p_rd_burst) else $error("burst rdy");
    property p_wr_rdy;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (wr_go && !cfg_s[CFG_SHORT_LAT]) ##1 wr_held[*2] |-> ##1 rdy_q;
    endproperty
    a_wr_rdy: assert property (p_wr_rdy) else $error("write rdy late");
    property p_wr_tail;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (state_q == ST_WR_BEAT && wr_held && beat_q == blen_m1)
            |=> rdy_q[*3] ##1 !rdy_q;
    endproperty
    a_wr_tail: assert property (p_wr_tail) else $error("write tail");
    property p_as_rd_end;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (state_q == ST_AS_RD && !rd_held) |=> !dq_oe_q;
    endproperty
    a_as_rd_end: assert property (p_as_rd_end) else $error("bus held");
    property p_as_wr_end;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (state_q == ST_AS_WR && !wr_held)
            |=> $changed(req_q) && wbase_q == $past(addr_q);
    endproperty
    a_as_wr_end: assert property (p_as_wr_end) else $error("write lost");
    property p_addr_cap;
        @(posedge LINK_CLK_I) disable iff (!link_rst_n)
        (!ctl.address_valid_n && !ctl.ce_n) ##1 ctl.address_valid_n
            |-> addr_q == $past(dq_in);
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("bad address");

    c_rd_burst: cover property (@(posedge LINK_CLK_I) disable iff
        (!link_rst_n) state_q == ST_RD_BEAT && beat_q == BURST_M1);
    c_wr_burst: cover property (@(posedge LINK_CLK_I) disable iff
        (!link_rst_n) state_q == ST_WR_TAIL && wlast_q == BURST_M1);
    c_as_wr: cover property (@(posedge LINK_CLK_I) disable iff
        (!link_rst_n) state_q == ST_AS_WR ##1 state_q == ST_IDLE);
    c_as_rd2: cover property (@(posedge LINK_CLK_I) disable iff
        (!link_rst_n) state_q == ST_AS_RD ##[1:20] state_q == ST_AS_RD);
endmodule
`default_nettype wire

// ### madhp_proc.sv
// processor model driving the muxed address/data pins
`timescale 1ns/1ps
`default_nettype none
module madhp_proc (
    // seen from the port
    input wire logic lclk_i,
    input wire logic rdy_i,
    input wire logic oe_i,
    input wire logic [madhp_pkg::DQ_W-1:0] bus_i,
    // driven pins
    output var madhp_pkg::madhp_ctl_t ctl_o,
    output logic [madhp_pkg::DQ_W-1:0] dq_o
);
    import madhp_pkg::*;
    logic drv = 1'b1;
    initial ctl_o = '1;
    initial dq_o = '0;
    // released bus must not keep a stale value
    always @(negedge lclk_i) begin
        if (!drv) dq_o <= ~dq_o;
    end
    // pins change just after the shared edge
    task automatic adr(input logic [DQ_W-1:0] a, input int n);
        @(posedge lclk_i);
        drv <= 1'b1;
        ctl_o.ce_n <= 1'b0;
        ctl_o.address_valid_n <= 1'b0;
        dq_o <= a;
        repeat (n) @(posedge lclk_i);
        ctl_o.address_valid_n <= 1'b1;
    endtask
    task automatic wait_rdy(output int lat);
        lat = -1;
        @(posedge lclk_i);
        do begin
            @(posedge lclk_i);
            lat++;
        end while (rdy_i !== 1'b1 && lat < 60);
    endtask
    // whole bursts, write enable held to the last word
    task automatic cwr(input logic [DQ_W-1:0] a, d, input int n,
                       output int lat, tail, gaps);
        int k;
        adr(a, 1);
        ctl_o.we_n <= 1'b0;
        dq_o <= d;
        gaps = 0;
        wait_rdy(lat);
        k = 1;
        while (k < n && gaps < 8) begin
            dq_o <= d + DQ_W'(k);
            @(posedge lclk_i);
            if (rdy_i === 1'b1) k++;
            else gaps++;
        end
        ctl_o.we_n <= 1'b1;
        tail = 0;
        @(posedge lclk_i);
        while (rdy_i === 1'b1 && tail < 60) begin
            tail++;
            @(posedge lclk_i);
        end
        ctl_o.ce_n <= 1'b1;
    endtask
    // output enable held for the whole burst
    task automatic crd(input logic [DQ_W-1:0] a, input int n,
                       output int lat, gaps,
                       output logic [3:0][DQ_W-1:0] w,
                       output logic [DQ_W-1:0] hold,
                       output logic aft, off);
        int k;
        adr(a, 1);
        ctl_o.oe_n <= 1'b0;
        drv <= 1'b0;
        gaps = 0;
        wait_rdy(lat);
        w = '0;
        w[0] = bus_i;
        k = 1;
        while (k < n && gaps < 8) begin
            @(posedge lclk_i);
            if (rdy_i === 1'b1) begin
                w[k] = bus_i;
                k++;
            end else gaps++;
        end
        @(posedge lclk_i);
        aft = rdy_i;
        hold = bus_i;
        ctl_o.oe_n <= 1'b1;
        repeat (2) @(posedge lclk_i);
        off = oe_i;
        ctl_o.ce_n <= 1'b1;
    endtask
    // chip select may stay low across accesses
    task automatic awr(input logic [DQ_W-1:0] a, d, input logic by_ce);
        adr(a, 4);
        ctl_o.we_n <= 1'b0;
        dq_o <= d;
        repeat (6) @(posedge lclk_i);
        if (by_ce) begin
            ctl_o.ce_n <= 1'b1;
            repeat (6) @(posedge lclk_i);
        end
        ctl_o.we_n <= 1'b1;
        repeat (6) @(posedge lclk_i);
    endtask
    task automatic ard(input logic [DQ_W-1:0] a, input logic by_ce,
                       output logic [DQ_W-1:0] d, output logic on, off);
        adr(a, 4);
        ctl_o.oe_n <= 1'b0;
        drv <= 1'b0;
        repeat (6) @(posedge lclk_i);
        d = bus_i;
        on = oe_i;
        if (by_ce) ctl_o.ce_n <= 1'b1;
        else ctl_o.oe_n <= 1'b1;
        repeat (5) @(posedge lclk_i);
        off = oe_i;
        ctl_o.oe_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### madhp_top_tb.sv
// testbench of the muxed address/data host port
`timescale 1ns/1ps
`default_nettype none
module madhp_top_tb;
    import madhp_pkg::*;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic mode = 1'b1;
    logic burst = 1'b0;
    logic short_lat = 1'b0;
    logic wr_ready = 1'b1;
    madhp_ctl_t ctl;
    logic [DQ_W-1:0] p_dq, bus, dq_o, hold, d;
    logic dq_oe, rdy, wr_valid, aft, on, off;
    madhp_word_t wr_word;
    madhp_word_t exp_q[$];
    logic [3:0][DQ_W-1:0] w;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int lat, tail, gaps;

    always #20 sys_clk = ~sys_clk;
    always #40 link_clk = ~link_clk;
    assign bus = dq_oe ? dq_o : p_dq;

    madhp_top u_madhp_top (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n),
        .MUXED_ADDR_DATA_MODE_I(mode), .BURST_MODE_I(burst),
        .SHORT_LAT_I(short_lat), .LINK_CLK_I(link_clk), .PIN_CTL_I(ctl),
        .DQ_I(bus), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .RDY_O(rdy),
        .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready), .WR_WORD_O(wr_word));
    madhp_proc u_madhp_proc (.lclk_i(link_clk), .rdy_i(rdy), .oe_i(dq_oe),
        .bus_i(bus), .ctl_o(ctl), .dq_o(p_dq));

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // every handed-off word must match the expected write order
    always @(posedge sys_clk) begin
        cyc++;
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            if (exp_q.size() == 0) chk("wr_extra", 0, wr_word);
            else chk("wr_word", exp_q.pop_front(), wr_word);
        end
        if (cyc == 8000) begin
            error_cnt++;
            $display("[ERR] cycles expected below 8000 seen %0d", cyc);
            conclude();
        end
    end
    task automatic wl(input int n);
        repeat (n) @(posedge link_clk);
    endtask
    task automatic drain();
        int i;
        // end on a system edge, so strap changes after it are aligned
        @(posedge sys_clk);
        for (i = 0; i < 80 && exp_q.size() > 0; i++) @(posedge sys_clk);
        chk("words_left", 0, exp_q.size());
    endtask
    task automatic t_single();
        exp_q.push_back({16'h0005, 16'h1234});
        u_madhp_proc.cwr(16'h0005, 16'h1234, 1, lat, tail, gaps);
        chk("wr_lat", 2, lat);
        chk("wr_tail", 3, tail);
        u_madhp_proc.crd(16'h0005, 1, lat, gaps, w, hold, aft, off);
        chk("rd_lat", 2, lat);
        chk("rd_data", 16'h1234, w[0]);
        chk("rd_rdy_drop", 0, aft);
        chk("rd_hold", 16'h1234, hold);
        chk("rd_oe_off", 0, off);
        drain();
        $display("test single done");
    endtask
    task automatic t_burst();
        int k;
        @(posedge sys_clk);
        burst <= 1'b1;
        wl(6);
        for (k = 0; k < 4; k++)
            exp_q.push_back({16'h000e + 16'(k), 16'h0a00 + 16'(k)});
        u_madhp_proc.cwr(16'h000e, 16'h0a00, 4, lat, tail, gaps);
        chk("bw_lat", 2, lat);
        chk("bw_tail", 3, tail);
        chk("bw_gaps", 0, gaps);
        u_madhp_proc.crd(16'h000e, 4, lat, gaps, w, hold, aft, off);
        chk("br_gaps", 0, gaps);
        for (k = 0; k < 4; k++) chk("br_word", 16'h0a00 + 16'(k), w[k]);
        chk("br_rdy_drop", 0, aft);
        chk("br_hold", 16'h0a03, hold);
        chk("br_oe_off", 0, off);
        drain();
        burst <= 1'b0;
        $display("test burst done");
    endtask
    task automatic t_short();
        @(posedge sys_clk);
        short_lat <= 1'b1;
        wl(6);
        u_madhp_proc.crd(16'h0005, 1, lat, gaps, w, hold, aft, off);
        chk("short_lat", 1, lat);
        chk("short_data", 16'h1234, w[0]);
        @(posedge sys_clk);
        short_lat <= 1'b0;
        wl(6);
        $display("test short latency done");
    endtask
    task automatic t_stall();
        int k;
        @(posedge sys_clk);
        wr_ready <= 1'b0;
        for (k = 0; k < 4; k++)
            exp_q.push_back({16'h0020 + 16'(k), 16'h0b00 + 16'(k)});
        // two words fill the buffer, the third stays pending in hand-off
        u_madhp_proc.cwr(16'h0020, 16'h0b00, 1, lat, tail, gaps);
        u_madhp_proc.cwr(16'h0021, 16'h0b01, 1, lat, tail, gaps);
        u_madhp_proc.cwr(16'h0022, 16'h0b02, 1, lat, tail, gaps);
        fork
            u_madhp_proc.cwr(16'h0023, 16'h0b03, 1, lat, tail, gaps);
            begin
                repeat (40) @(posedge sys_clk);
                chk("stall_valid", 1, wr_valid);
                wr_ready <= 1'b1;
            end
        join
        chk("stall_rdy_late", 1, lat > 2);
        drain();
        $display("test stall done");
    endtask
    task automatic t_async();
        @(posedge sys_clk);
        mode <= 1'b0;
        wl(6);
        exp_q.push_back({16'h0003, 16'h0c03});
        exp_q.push_back({16'h0007, 16'h0c07});
        u_madhp_proc.awr(16'h0003, 16'h0c03, 1'b0);
        u_madhp_proc.awr(16'h0007, 16'h0c07, 1'b1);
        drain();
        u_madhp_proc.ard(16'h0003, 1'b0, d, on, off);
        chk("as_data", 16'h0c03, d);
        chk("as_on", 1, on);
        chk("as_off_oe", 0, off);
        u_madhp_proc.ard(16'h0007, 1'b1, d, on, off);
        chk("as_data", 16'h0c07, d);
        chk("as_off_ce", 0, off);
        $display("test async done");
    endtask

    initial begin
        repeat (15) @(posedge sys_clk);
        chk("rst_rdy", 0, rdy);
        chk("rst_oe", 0, dq_oe);
        chk("rst_valid", 0, wr_valid);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        wl(6);
        t_single();
        t_burst();
        t_short();
        t_stall();
        t_async();
        conclude();
    end
endmodule
`default_nettype wire
